// file: hw/lec_cfg.svh
// Purpose: constants of the link feature and subsystem alias registers
// Assumes: byte addresses of the configuration space, 32-bit words
// Notes: thresholds are in bytes of transmit fifo fill
`ifndef LEC_CFG_SVH
`define LEC_CFG_SVH
`define LEC_OFS_FEAT 8'hf4
`define LEC_OFS_ALIAS 8'hf8
`define LEC_FEAT_RST 16'h1000
`define LEC_FEAT_WMASK 16'hb582
`define LEC_ALIAS_RST 32'h00000000
`define LEC_B_PIPE 15
`define LEC_B_THR_HI 13
`define LEC_B_THR_LO 12
`define LEC_B_MPEG 10
`define LEC_B_DV 8
`define LEC_B_PRIO 7
`define LEC_B_PROG 6
`define LEC_B_ACCEL 1
`define LEC_THR_2K 12'h800
`define LEC_THR_1K7 12'h6cc
`define LEC_THR_1K 12'h400
`define LEC_THR_512 12'h200
`define LEC_FMT_MPEG 6'h20
`define LEC_FMT_DV 6'h00
`endif

// file: hw/lec_pkg.sv
// Purpose: types shared by the link feature register bank
// Assumes: one-hot transmit sequencer
// Notes: threshold codes follow the two-bit select field
package lec_pkg;
  typedef enum logic [2:0] {
    LEC_ST_IDLE = 3'b001,
    LEC_ST_FILL = 3'b010,
    LEC_ST_SEND = 3'b100
  } lec_at_st_t;
  typedef enum logic [1:0] {
    LEC_THR_SF = 2'b00,
    LEC_THR_1K7 = 2'b01,
    LEC_THR_1K = 2'b10,
    LEC_THR_512 = 2'b11
  } lec_thr_t;
endpackage

// file: hw/lec_at_thresh.sv
// Purpose: asynchronous transmit start control with underrun fallback
// Assumes: fifo status comes from logic on the same clock
// Notes: fallback latch clears only on request from the register bank
`timescale 1ns/10ps
`include "lec_cfg.svh"
module lec_at_thresh
  import lec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] thr_sel_i,
  input wire logic gate_i,
  input wire logic retries_zero_i,
  input wire logic pkt_pend_i,
  input wire logic [11:0] fifo_level_i,
  input wire logic pkt_loaded_i,
  input wire logic fifo_empty_i,
  input wire logic tx_done_i,
  input wire logic sf_clr_i,
  output logic tx_start_o,
  output logic underrun_o,
  output logic sf_fallback_o
);
  lec_at_st_t st_r, st_nxt;
  logic [11:0] thr;
  logic sf, start_ok, under_det;

  always_comb begin
    case (lec_thr_t'(thr_sel_i))
      LEC_THR_1K7: thr = `LEC_THR_1K7;
      LEC_THR_1K: thr = `LEC_THR_1K;
      LEC_THR_512: thr = `LEC_THR_512;
      default: thr = `LEC_THR_2K;
    endcase
  end

  // store-and-forward whenever any cause is present
  assign sf = sf_fallback_o | retries_zero_i | !gate_i |
              (thr_sel_i == LEC_THR_SF);
  // a full packet always may go; threshold only outside store-and-forward
  assign start_ok = pkt_loaded_i | (!sf & (fifo_level_i >= thr));
  assign under_det = (st_r == LEC_ST_SEND) & fifo_empty_i & !pkt_loaded_i;
  assign tx_start_o = (st_r == LEC_ST_FILL) & start_ok;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      LEC_ST_IDLE: if (pkt_pend_i) st_nxt = LEC_ST_FILL;
      LEC_ST_FILL: if (start_ok) st_nxt = LEC_ST_SEND;
      LEC_ST_SEND: begin
        if (under_det) st_nxt = LEC_ST_FILL;
        else if (tx_done_i) st_nxt = LEC_ST_IDLE;
      end
      default: st_nxt = LEC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) st_r <= LEC_ST_IDLE;
    else if (ce_i) st_r <= st_nxt;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) underrun_o <= 1'b0;
    else if (ce_i) underrun_o <= under_det;
  end

  // set wins over clear so an underrun is never forgotten
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) sf_fallback_o <= 1'b0;
    else if (ce_i) begin
      if (under_det) sf_fallback_o <= 1'b1;
      else if (sf_clr_i) sf_fallback_o <= 1'b0;
    end
  end

  sequence s_underrun;
    ce_i && st_r == LEC_ST_SEND && fifo_empty_i && !pkt_loaded_i;
  endsequence
  sequence s_fallback;
    underrun_o && sf_fallback_o && st_r == LEC_ST_FILL;
  endsequence

  a_underrun_fallback: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) s_underrun |=> s_fallback)
    else $error("underrun did not force fallback");
  a_sf_no_early: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (st_r == LEC_ST_FILL && !pkt_loaded_i &&
     (thr_sel_i == 2'b00 || sf_fallback_o || !gate_i)) |-> !tx_start_o)
    else $error("start before end of packet in store-and-forward");
  a_thr_start: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (st_r == LEC_ST_FILL && thr_sel_i != 2'b00 && !sf_fallback_o &&
     !retries_zero_i && gate_i && fifo_level_i >= thr) |-> tx_start_o)
    else $error("threshold reached without start");
  a_retries_sf: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (st_r == LEC_ST_FILL && retries_zero_i && !pkt_loaded_i
     && fifo_level_i >= `LEC_THR_512) |-> !tx_start_o)
    else $error("start with retries cleared");
  a_thr_map: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (thr_sel_i == 2'b01) |-> thr == `LEC_THR_1K7)
    else $error("threshold code mapping wrong");
endmodule // lec_at_thresh

// file: hw/lec_regs.sv
// Purpose: link feature control and subsystem alias register bank
// Assumes: configuration accesses arrive on the system clock
// Notes: one access per strobe, answered one cycle later
// Behaviour
// - threshold code 00 means 2K store-and-forward, 01 1.7K, 10 1K, 11 512.
// - below 2K, sending starts at the threshold or at full packet load.
// - a fifo that empties before the packet end is an underrun.
// - after an underrun the retry waits for the whole packet.
// - with the 2K code no data goes out before the end-of-packet token.
// - a zero retries setting always forces store-and-forward.
// - bit 10 enables the timestamp boost for streams of format 20h.
// - bit 8 enables the timestamp boost for streams of format 00h.
// - bit 7 makes the link answer requests with priority arbitration.
// - bit 1 tells the phy that acceleration features are supported.
// - bits 14, 11, 9, 5 to 2 and 0 of the feature register read zero.
// - bit 6 reads zero; its loaded value feeds the phy program gate.
// - a write to the alias register updates the subsystem identifiers.
// - a read of the alias register returns the last written value.
// - the alias holds device id in bits 31-16 and vendor id in 15-0.
// - the threshold holds until an underrun, then 2K is used until the next threshold write.
// - feature bits act only while the phy feature gate is set, except the loaded bit 6, which drives the program gate regardless.
`timescale 1ns/10ps
`include "lec_cfg.svh"
module lec_regs
  import lec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic eep_load_i,
  input wire logic [15:0] eep_data_i,
  input wire logic phy_feature_gate_i,
  input wire logic retries_zero_i,
  input wire logic pkt_pend_i,
  input wire logic [11:0] fifo_level_i,
  input wire logic pkt_loaded_i,
  input wire logic fifo_empty_i,
  input wire logic tx_done_i,
  input wire logic [5:0] stream_fmt_i,
  output logic tx_start_o,
  output logic underrun_o,
  output logic sf_fallback_o,
  output logic pipe_off_o,
  output logic mpeg_stamp_boost_o,
  output logic dv_stamp_boost_o,
  output logic stamp_apply_o,
  output logic prio_req_o,
  output logic accel_o,
  output logic phy_program_gate_o,
  output logic [15:0] subsys_device_alias_o,
  output logic [15:0] subsys_vendor_alias_o,
  output logic subsys_upd_o
);
  localparam logic [15:0] WMASK = `LEC_FEAT_WMASK;

  logic rst_q1_r, rst_n;
  logic [15:0] feat_r, feat_nxt;
  logic [31:0] alias_r;
  logic wr_feat, wr_alias, rd_feat, rd_alias;
  logic sf_clr;

  // reset is released through two stages so that release is synchronous
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n <= rst_q1_r;
    end
  end

  assign wr_feat = cfg_wr_i & (cfg_addr_i == `LEC_OFS_FEAT);
  assign wr_alias = cfg_wr_i & (cfg_addr_i == `LEC_OFS_ALIAS);
  assign rd_feat = cfg_rd_i & (cfg_addr_i == `LEC_OFS_FEAT);
  assign rd_alias = cfg_rd_i & (cfg_addr_i == `LEC_OFS_ALIAS);
  // a new threshold write ends an earlier underrun fallback
  assign sf_clr = wr_feat & cfg_be_i[1];

  // only writable positions are stored; reserved ones stay zero
  always_comb begin
    feat_nxt = feat_r;
    if (eep_load_i) begin
      feat_nxt = eep_data_i & WMASK;
    end else if (wr_feat) begin
      if (cfg_be_i[0]) feat_nxt[7:0] = cfg_wdata_i[7:0] & WMASK[7:0];
      if (cfg_be_i[1]) feat_nxt[15:8] = cfg_wdata_i[15:8] & WMASK[15:8];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) feat_r <= `LEC_FEAT_RST;
    else if (ce_i) feat_r <= feat_nxt;
  end

  // the eeprom bit at the unassigned position steers the program gate
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) phy_program_gate_o <= 1'b0;
    else if (ce_i && eep_load_i)
      phy_program_gate_o <= eep_data_i[`LEC_B_PROG];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_alias_lane
      always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) alias_r[8*gi +: 8] <= 8'h00;
        else if (ce_i && wr_alias && cfg_be_i[gi])
          alias_r[8*gi +: 8] <= cfg_wdata_i[8*gi +: 8];
      end
    end
  endgenerate

  // identifiers take the write data on the same edge that loads the alias
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      subsys_device_alias_o <= 16'h0000;
      subsys_vendor_alias_o <= 16'h0000;
      subsys_upd_o <= 1'b0;
    end else if (ce_i) begin
      subsys_upd_o <= wr_alias;
      if (wr_alias && cfg_be_i[2])
        subsys_device_alias_o[7:0] <= cfg_wdata_i[23:16];
      if (wr_alias && cfg_be_i[3])
        subsys_device_alias_o[15:8] <= cfg_wdata_i[31:24];
      if (wr_alias && cfg_be_i[0])
        subsys_vendor_alias_o[7:0] <= cfg_wdata_i[7:0];
      if (wr_alias && cfg_be_i[1])
        subsys_vendor_alias_o[15:8] <= cfg_wdata_i[15:8];
    end
  end

  // unmapped reads answer zero; unmapped writes are dropped
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_o <= 32'h00000000;
      cfg_ack_o <= 1'b0;
    end else if (ce_i) begin
      cfg_ack_o <= cfg_rd_i | cfg_wr_i;
      if (rd_feat) cfg_rdata_o <= {16'h0000, feat_r & WMASK};
      else if (rd_alias) cfg_rdata_o <= alias_r;
      else if (cfg_rd_i) cfg_rdata_o <= 32'h00000000;
    end
  end

  // every feature output is held off while the phy gate is low
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pipe_off_o <= 1'b0;
      mpeg_stamp_boost_o <= 1'b0;
      dv_stamp_boost_o <= 1'b0;
      prio_req_o <= 1'b0;
      accel_o <= 1'b0;
    end else if (ce_i) begin
      pipe_off_o <= feat_r[`LEC_B_PIPE] & phy_feature_gate_i;
      mpeg_stamp_boost_o <= feat_r[`LEC_B_MPEG] &
                            phy_feature_gate_i;
      dv_stamp_boost_o <= feat_r[`LEC_B_DV] &
                          phy_feature_gate_i;
      prio_req_o <= feat_r[`LEC_B_PRIO] & phy_feature_gate_i;
      accel_o <= feat_r[`LEC_B_ACCEL] & phy_feature_gate_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) stamp_apply_o <= 1'b0;
    else if (ce_i)
      stamp_apply_o <= (mpeg_stamp_boost_o &&
                        stream_fmt_i == `LEC_FMT_MPEG) ||
                       (dv_stamp_boost_o &&
                        stream_fmt_i == `LEC_FMT_DV);
  end

  // threshold code is gated with the phy gate inside the sequencer
  lec_at_thresh u_at_thresh (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .thr_sel_i(feat_r[`LEC_B_THR_HI:`LEC_B_THR_LO]),
    .gate_i(phy_feature_gate_i),
    .retries_zero_i(retries_zero_i),
    .pkt_pend_i(pkt_pend_i),
    .fifo_level_i(fifo_level_i),
    .pkt_loaded_i(pkt_loaded_i),
    .fifo_empty_i(fifo_empty_i),
    .tx_done_i(tx_done_i),
    .sf_clr_i(sf_clr & ce_i),
    .tx_start_o(tx_start_o),
    .underrun_o(underrun_o),
    .sf_fallback_o(sf_fallback_o)
  );

  a_rsvd_zero: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && rd_feat) |=> (cfg_rdata_o & 32'hffff4a7d) == 32'h00000000)
    else $error("reserved feature bit read nonzero");
  sequence s_alias_wr;
    ce_i && wr_alias && cfg_be_i == 4'hf;
  endsequence
  sequence s_alias_rd;
    ce_i && rd_alias;
  endsequence
  a_alias_back: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    s_alias_wr ##1 s_alias_rd
    |=> cfg_rdata_o == $past(cfg_wdata_i, 2))
    else $error("alias readback differs from last write");
  a_alias_upd: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && wr_alias && cfg_be_i == 4'hf) |=> subsys_upd_o &&
    {subsys_device_alias_o, subsys_vendor_alias_o} == $past(cfg_wdata_i))
    else $error("subsystem identifiers not updated");
  a_field_split: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && wr_alias && cfg_be_i == 4'b1100) |=>
    subsys_device_alias_o == $past(cfg_wdata_i[31:16]) &&
    $stable(subsys_vendor_alias_o))
    else $error("alias fields misplaced");
  a_mpeg_gate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && !phy_feature_gate_i) |=> !mpeg_stamp_boost_o && !accel_o)
    else $error("feature active without phy gate");
  a_stamp_fmt: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && dv_stamp_boost_o && stream_fmt_i == 6'h00) |=> stamp_apply_o)
    else $error("dv stamp boost not applied");
  a_prio_arb: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && phy_feature_gate_i && feat_r[7]) |=> prio_req_o)
    else $error("priority request not enabled");
  a_accel_flag: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && phy_feature_gate_i && !feat_r[1]) |=> !accel_o)
    else $error("acceleration flagged while disabled");
  a_accel_on: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && phy_feature_gate_i && feat_r[1]) |=> accel_o)
    else $error("acceleration not flagged");
  a_prio_off: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && !feat_r[7]) |=> !prio_req_o)
    else $error("priority request while disabled");
  a_mpeg_on: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && phy_feature_gate_i && feat_r[10]) |=> mpeg_stamp_boost_o)
    else $error("mpeg stamp boost not enabled");
  a_dv_on: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && phy_feature_gate_i && feat_r[8]) |=> dv_stamp_boost_o)
    else $error("dv stamp boost not enabled");
  a_pipe_on: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && phy_feature_gate_i && feat_r[15]) |=> pipe_off_o)
    else $error("pipelining disable not passed on");
  a_dv_gate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && !phy_feature_gate_i) |=>
    !dv_stamp_boost_o && !prio_req_o && !pipe_off_o)
    else $error("feature output active without phy gate");
  a_stamp_mpeg: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && mpeg_stamp_boost_o && stream_fmt_i == 6'h20) |=> stamp_apply_o)
    else $error("mpeg stamp boost not applied");
  a_stamp_off: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && !mpeg_stamp_boost_o && !dv_stamp_boost_o) |=> !stamp_apply_o)
    else $error("stamp applied with both boosts off");
  a_rsvd_store: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (feat_r & 16'h4a7d) == 16'h0000)
    else $error("reserved feature bit stored");
  a_feat_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && wr_feat && !eep_load_i && cfg_be_i == 4'h3) |=>
    feat_r == ($past(cfg_wdata_i[15:0]) & 16'hb582))
    else $error("feature write not stored");
  a_eep_load: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && eep_load_i) |=> feat_r == ($past(eep_data_i) & 16'hb582) &&
    phy_program_gate_o == $past(eep_data_i[6]))
    else $error("eeprom load not applied");
  a_rd_ack: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && cfg_rd_i) |=> cfg_ack_o)
    else $error("read not acknowledged");
  a_wr_ack: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && cfg_wr_i) |=> cfg_ack_o)
    else $error("write not acknowledged");
  a_upd_pulse: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && !wr_alias) |=> !subsys_upd_o)
    else $error("identifier update without alias write");
  a_ident_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && !wr_alias) |=>
    $stable(subsys_device_alias_o) && $stable(subsys_vendor_alias_o))
    else $error("identifiers changed without alias write");
  a_alias_lane: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    (ce_i && wr_alias && cfg_be_i == 4'b0011) |=>
    alias_r[15:0] == $past(cfg_wdata_i[15:0]) && $stable(alias_r[31:16]))
    else $error("vendor lane write misplaced");
  a_ce_freeze: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n)
    !ce_i |=> $stable(feat_r) && $stable(alias_r) &&
    $stable(cfg_ack_o) && $stable(cfg_rdata_o))
    else $error("state moved with clock enable low");
endmodule // lec_regs

// file: tb/tb.sv
// Purpose: self-checking bench for the link feature register bank
// Assumes: one-cycle strobes, ack and read data one cycle later
// Notes: model registers are kept here and compared at every result
`timescale 1ns/10ps
`include "lec_cfg.svh"
module tb;
  import lec_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic cfg_rd_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic eep_load_i = 1'b0;
  logic [15:0] eep_data_i = 16'h0;
  logic gate = 1'b1;
  logic rz = 1'b0;
  logic pend = 1'b0;
  logic [11:0] lvl = 12'h0;
  logic ld = 1'b0;
  logic emp = 1'b0;
  logic done = 1'b0;
  logic [5:0] fmt = 6'h00;
  logic [31:0] cfg_rdata_o;
  logic cfg_ack_o, tx_start_o, underrun_o, sf_fallback_o, pipe_off_o;
  logic mpeg_o, dv_o, stamp_o, prio_o, accel_o, pgate_o, upd_o;
  logic [15:0] dev_o, ven_o;
  logic [31:0] feat_m = 32'h00001000;
  logic [31:0] alias_m = 32'h0;
  int fail_count = 0;
  int comparisons = 0;
  int thr_tab[4] = '{32'h800, 32'h6cc, 32'h400, 32'h200};
  lec_regs i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
    .eep_load_i(eep_load_i), .eep_data_i(eep_data_i),
    .phy_feature_gate_i(gate), .retries_zero_i(rz), .pkt_pend_i(pend),
    .fifo_level_i(lvl), .pkt_loaded_i(ld), .fifo_empty_i(emp),
    .tx_done_i(done), .stream_fmt_i(fmt), .tx_start_o(tx_start_o),
    .underrun_o(underrun_o), .sf_fallback_o(sf_fallback_o),
    .pipe_off_o(pipe_off_o), .mpeg_stamp_boost_o(mpeg_o),
    .dv_stamp_boost_o(dv_o), .stamp_apply_o(stamp_o), .prio_req_o(prio_o),
    .accel_o(accel_o), .phy_program_gate_o(pgate_o),
    .subsys_device_alias_o(dev_o), .subsys_vendor_alias_o(ven_o),
    .subsys_upd_o(upd_o));
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    chk32({31'h0, e}, {31'h0, g});
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q);
    @(negedge clk_sys_i);
    cfg_wr_i = w;
    cfg_rd_i = !w;
    cfg_addr_i = a;
    cfg_be_i = be;
    cfg_wdata_i = d;
    @(negedge clk_sys_i);
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b0;
    chk1(1'b1, cfg_ack_o);
    q = cfg_rdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    logic [31:0] q, m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    acc(1'b1, a, be, d, q);
    // only bits 15, 13, 12, 10, 8, 7 and 1 are writable
    if (a == 8'hf4) feat_m = (feat_m & ~(m & 32'hb582)) | (d & m & 32'hb582);
    if (a == 8'hf8) begin
      alias_m = (alias_m & ~m) | (d & m);
      chk1(1'b1, upd_o);
      chk32(alias_m, {dev_o, ven_o});
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] q;
    acc(1'b0, a, 4'h0, 32'h0, q);
    chk32(a == 8'hf4 ? feat_m : a == 8'hf8 ? alias_m : 32'h0, q);
  endtask
  task automatic chk_feat();
    repeat (3) @(negedge clk_sys_i);
    chk1(feat_m[15] & gate, pipe_off_o);
    chk1(feat_m[10] & gate, mpeg_o);
    chk1(feat_m[8] & gate, dv_o);
    chk1(feat_m[7] & gate, prio_o);
    chk1(feat_m[1] & gate, accel_o);
    chk1(gate & ((feat_m[10] & fmt == 6'h20) | (feat_m[8] & fmt == 6'h00)),
      stamp_o);
  endtask
  task automatic pkt(input int thr, input logic sf, input logic ur);
    @(negedge clk_sys_i);
    pend = 1'b1;
    lvl = 12'(thr - 1);
    @(negedge clk_sys_i);
    #1 chk1(1'b0, tx_start_o);
    @(negedge clk_sys_i);
    lvl = 12'(thr);
    #1 chk1(!sf, tx_start_o);
    if (sf) begin
      @(negedge clk_sys_i);
      ld = 1'b1;
      #1 chk1(1'b1, tx_start_o);
    end
    @(negedge clk_sys_i);
    ld = 1'b0;
    if (ur) begin
      emp = 1'b1;
      @(negedge clk_sys_i);
      emp = 1'b0;
      chk1(1'b1, underrun_o);
      chk1(1'b1, sf_fallback_o);
      lvl = 12'hfff;
      #1 chk1(1'b0, tx_start_o);
      @(negedge clk_sys_i);
      ld = 1'b1;
      #1 chk1(1'b1, tx_start_o);
      chk1(1'b0, underrun_o);
      @(negedge clk_sys_i);
      ld = 1'b0;
    end
    pend = 1'b0;
    done = 1'b1;
    @(negedge clk_sys_i);
    done = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h0ea2));
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(8'hf4);
    rd(8'hf8);
    chk1(1'b0, sf_fallback_o);
    $display("test reset done");
    wr(8'hf4, 4'hf, 32'hffffffff);
    rd(8'hf4);
    chk_feat();
    gate = 1'b0;
    chk_feat();
    gate = 1'b1;
    wr(8'hf0, 4'hf, $urandom);
    rd(8'hf0);
    for (int i = 0; i < 4; i++) begin
      wr(8'hf4, 4'h3, i[1] ? 32'h1100 : 32'h1400);
      fmt = i[0] ? 6'h20 : 6'h00;
      chk_feat();
    end
    $display("test feature bits done");
    for (int i = 0; i < 4; i++) begin
      wr(8'hf8, 4'($urandom), $urandom);
      rd(8'hf8);
    end
    // strobe with the clock enable low must leave the alias alone
    @(negedge clk_sys_i);
    ce_i = 1'b0;
    cfg_wr_i = 1'b1;
    cfg_addr_i = 8'hf8;
    cfg_be_i = 4'hf;
    @(negedge clk_sys_i);
    cfg_wr_i = 1'b0;
    ce_i = 1'b1;
    rd(8'hf8);
    $display("test alias done");
    eep_data_i = 16'hffff;
    eep_load_i = 1'b1;
    @(negedge clk_sys_i);
    eep_load_i = 1'b0;
    feat_m = 32'hb582;
    repeat (2) @(negedge clk_sys_i);
    chk1(1'b1, pgate_o);
    rd(8'hf4);
    $display("test eeprom done");
    for (int c = 0; c < 4; c++) begin
      wr(8'hf4, 4'h2, 32'(c) << 12);
      pkt(thr_tab[c], c == 0, 1'b0);
    end
    rz = 1'b1;
    pkt(32'h200, 1'b1, 1'b0);
    rz = 1'b0;
    gate = 1'b0;
    pkt(32'h200, 1'b1, 1'b0);
    gate = 1'b1;
    $display("test thresholds done");
    wr(8'hf4, 4'h2, 32'h1000);
    pkt(32'h6cc, 1'b0, 1'b1);
    pkt(32'h6cc, 1'b1, 1'b0);
    wr(8'hf4, 4'h2, 32'h1000);
    chk1(1'b0, sf_fallback_o);
    pkt(32'h6cc, 1'b0, 1'b0);
    $display("test underrun done");
    wrap_up();
  end
endmodule // tb
